// ==== bench/wdt_sys_model.sv ====
// system reset and interrupt logic that stands behind the watchdog timer unit
// assumes one aclk domain; a reset request is answered by a fixed-length system reset
module wdt_sys_model #(
    parameter int RST_LEN = 4
) (
    input  wire logic aclk,
    input  wire logic wdt_irq,
    input  wire logic wdt_reset_req,
    output logic      sys_rst_n,
    output int        n_resets,
    output int        n_irqs
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // reset pulse and interrupt count
    int   hold_ff;
    logic irq_q_ff;

    initial begin
        sys_rst_n = 1'b1;
        hold_ff   = 0;
        n_resets  = 0;
        n_irqs    = 0;
        irq_q_ff  = 1'b0;
    end

    // the request is sticky until reset, so only a fresh request after the pulse counts again
    always @(posedge aclk) begin
        irq_q_ff <= wdt_irq;
        if (wdt_irq === 1'b1 && irq_q_ff !== 1'b1) begin
            n_irqs <= n_irqs + 1;
        end
        if (hold_ff > 0) begin
            hold_ff   <= hold_ff - 1;
            sys_rst_n <= (hold_ff == 1);
        end else if (wdt_reset_req === 1'b1) begin
            hold_ff   <= RST_LEN;
            sys_rst_n <= 1'b0;
            n_resets  <= n_resets + 1;
        end
    end
endmodule

// ==== bench/wdt_top_tb.sv ====
// self-checking bench of the watchdog timer unit over its AXI4-Lite registers
// assumes wdt_top and the system model wdt_sys_model; expiry resets come back through it
`include "wdt_map.svh"

module wdt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // clock, reset and wiring
    localparam int SRC_DIV = 4;  // short tick keeps the 256 prescale run near 2000 cycles
    logic        aclk;
    logic        tb_rst_n;
    wire logic   aresetn;
    logic [31:0] awaddr, wdata, araddr, rdata, c1, c2;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic        awvalid, wvalid, arvalid, bready, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        wdt_irq, wdt_reset_req, sys_rst_n;
    logic [7:0]  seq;
    int          error_cnt, n_compared, n_resets, n;
    int          lo_t[4] = '{39, 2, 0, 39};
    int          hi_t[4] = '{42, 3, 1, 42};

    assign aresetn = tb_rst_n & sys_rst_n;
    initial aclk = 1'b0;
    always #2 aclk = ~aclk;

    wdt_top #(.SRC_DIV(SRC_DIV)) i_wdt_top (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req)
    );

    wdt_sys_model i_wdt_sys_model (
        .aclk(aclk), .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req),
        .sys_rst_n(sys_rst_n), .n_resets(n_resets), .n_irqs()
    );

    // ==========================================================
    // comparisons and verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_compared++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // bus cycles: handshakes are judged mid-cycle, released just after the taking edge
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_go, w_go, b_go;
        int t;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        t = 0;
        do begin
            @(negedge aclk);
            aw_go = awvalid && awready;
            w_go  = wvalid && wready;
            b_go  = bvalid && bready;
            r     = bresp;
            @(posedge aclk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
            t++;
        end while (!b_go && t < 100);
        check({31'h0, b_go}, 32'h1);
    endtask

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d);
        bit ar_go, r_go;
        int t;
        araddr  <= a;
        arvalid <= 1'b1;
        t = 0;
        do begin
            @(negedge aclk);
            ar_go = arvalid && arready;
            r_go  = rvalid && rready;
            d     = rdata;
            rsp   = rresp;
            @(posedge aclk);
            if (ar_go) arvalid <= 1'b0;
            t++;
        end while (!r_go && t < 100);
        check({31'h0, r_go}, 32'h1);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        axi_write(a, d, rsp);
        check({30'h0, rsp}, {30'h0, wdt_pkg::WDT_RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        axi_read(a, d);
        check(d, exp);
    endtask

    task automatic chk_out(input logic irq, input logic rst);
        @(negedge aclk);
        check({31'h0, wdt_irq}, {31'h0, irq});
        check({31'h0, wdt_reset_req}, {31'h0, rst});
        @(posedge aclk);
    endtask

    // n comes back as lim + 1 when the flag never rose
    task automatic wait_flag(input bit sel, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(negedge aclk);
            cnt++;
        end while (((sel ? wdt_reset_req : wdt_irq) !== 1'b1) && cnt <= lim);
        @(posedge aclk);
    endtask

    task automatic sys_reset();
        tb_rst_n <= 1'b0;
        repeat (2) @(posedge aclk);
        tb_rst_n <= 1'b1;
        @(posedge aclk);
    endtask

    function automatic logic [7:0] seq_next(input logic [7:0] s);
        return {s[6:0], 1'b0} ^ (s[7] ? 8'h63 : 8'h00);
    endfunction

    // ==========================================================
    // tests
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        error_cnt = 0;
        n_compared = 0;
        tb_rst_n = 1'b0;
        {awaddr, wdata, araddr, awvalid, wvalid, arvalid} = '0;
        wstrb = 4'hf;
        bready = 1'b1;
        rready = 1'b1;
        repeat (20) @(posedge aclk);
        tb_rst_n <= 1'b1;
        @(posedge aclk);
        rd_chk(`WDT_RELOAD_ADDR, 32'h0);
        rd_chk(`WDT_COUNT_ADDR, 32'hffff);
        rd_chk(`WDT_CTRL_ADDR, 32'h0);
        rd_chk(`WDT_SERVICE_ADDR, 32'h0);
        axi_write(32'hffff0370, 32'h1, rsp);
        check({30'h0, rsp}, {30'h0, wdt_pkg::WDT_RESP_SLVERR});
        wr(`WDT_RELOAD_ADDR, 32'h1234);
        rd_chk(`WDT_RELOAD_ADDR, 32'h1234);
        wr(`WDT_COUNT_ADDR, 32'h0);
        rd_chk(`WDT_COUNT_ADDR, 32'hffff);
        wr(`WDT_CTRL_ADDR, 32'hffdf);
        rd_chk(`WDT_CTRL_ADDR, 32'h01de);
        // each prescale code on a free-running down count, step count over a fixed span
        for (int p = 0; p < 4; p++) begin
            wr(`WDT_CTRL_ADDR, 32'h0080 | (32'(p) << 2));
            axi_read(`WDT_COUNT_ADDR, c1);
            repeat (160) @(posedge aclk);
            axi_read(`WDT_COUNT_ADDR, c2);
            check_rng({16'h0, c1[15:0] - c2[15:0]}, lo_t[p], hi_t[p]);
        end
        wr(`WDT_CTRL_ADDR, 32'h0180);
        axi_read(`WDT_COUNT_ADDR, c1);
        repeat (40) @(posedge aclk);
        axi_read(`WDT_COUNT_ADDR, c2);
        check_rng({16'h0, c2[15:0] - c1[15:0]}, 9, 12);
        wr(`WDT_CTRL_ADDR, 32'h0);
        axi_read(`WDT_COUNT_ADDR, c1);
        repeat (40) @(posedge aclk);
        axi_read(`WDT_COUNT_ADDR, c2);
        check_rng({16'h0, c2[15:0] - c1[15:0]}, 0, 0);
        wr(`WDT_SERVICE_ADDR, 32'h0);
        chk_out(1'b0, 1'b0);
        // a control write reloads the count only on entry to watchdog mode, so start from the reset value:
        // an up count wraps at once, then a short periodic down count reaches zero
        sys_reset();
        wr(`WDT_RELOAD_ADDR, 32'h3);
        wr(`WDT_CTRL_ADDR, 32'h0180);
        wait_flag(1'b0, 8, n);
        check_rng(n, 1, 8);
        wr(`WDT_CTRL_ADDR, 32'h00c0);
        wr(`WDT_SERVICE_ADDR, 32'h0);
        wait_flag(1'b0, 40, n);
        check_rng(n, 1, 40);
        axi_read(`WDT_COUNT_ADDR, c1);
        check_rng(c1, 0, 3);
        wr(`WDT_CTRL_ADDR, 32'h0);
        repeat (20) @(posedge aclk);
        chk_out(1'b1, 1'b0);
        wr(`WDT_SERVICE_ADDR, 32'h5a);
        chk_out(1'b0, 1'b0);
        // watchdog with interrupt option, serviced then left to expire
        wr(`WDT_RELOAD_ADDR, 32'ha);
        wr(`WDT_CTRL_ADDR, 32'h22);
        for (int i = 0; i < 5; i++) begin
            repeat (20) @(posedge aclk);
            wr(`WDT_SERVICE_ADDR, 32'(i * 37));
            chk_out(1'b0, 1'b0);
        end
        wr(`WDT_RELOAD_ADDR, 32'h7);
        rd_chk(`WDT_RELOAD_ADDR, 32'ha);
        wr(`WDT_CTRL_ADDR, 32'h0);
        rd_chk(`WDT_CTRL_ADDR, 32'h22);
        axi_read(`WDT_COUNT_ADDR, c1);
        check_rng(c1, 0, 10);
        wait_flag(1'b0, 60, n);
        check_rng(n, 1, 60);
        chk_out(1'b1, 1'b0);
        wr(`WDT_SERVICE_ADDR, 32'h0);
        chk_out(1'b0, 1'b0);
        sys_reset();
        // secure clear: seeded sequence kept three times, then a wrong value
        wr(`WDT_SERVICE_ADDR, 32'haa);
        wr(`WDT_RELOAD_ADDR, 32'h40);
        wr(`WDT_CTRL_ADDR, 32'h32);
        seq = 8'haa;
        for (int i = 0; i < 3; i++) begin
            wr(`WDT_SERVICE_ADDR, {24'h0, seq});
            chk_out(1'b0, 1'b0);
            seq = seq_next(seq);
        end
        wr(`WDT_SERVICE_ADDR, {24'h0, seq ^ 8'hba});
        wait_flag(1'b1, 4, n);
        check_rng(n, 1, 4);
        repeat (10) @(posedge aclk);
        rd_chk(`WDT_CTRL_ADDR, 32'h0);
        wr(`WDT_SERVICE_ADDR, 32'h0);
        wr(`WDT_RELOAD_ADDR, 32'h40);
        wr(`WDT_CTRL_ADDR, 32'h32);
        wr(`WDT_SERVICE_ADDR, 32'h0);
        wait_flag(1'b1, 4, n);
        check_rng(n, 1, 4);
        repeat (10) @(posedge aclk);
        // longest prescale: two steps of 256 ticks before the reset request
        wr(`WDT_RELOAD_ADDR, 32'h2);
        wr(`WDT_CTRL_ADDR, 32'h28);
        wait_flag(1'b1, 3000, n);
        check_rng(n, 1000, 2100);
        repeat (10) @(posedge aclk);
        check(32'(n_resets), 32'h3);
        tally_and_finish();
    end
endmodule

// ==== logic/wdt_top.sv ====
// watchdog timer unit: 16-bit timer with normal and watchdog modes, AXI4-Lite slave
// assumes one 250 MHz clock, synchronous active-low reset, one write and one read in flight
//
// Notes on behaviour
// - control bit 5 selects watchdog mode
// - watchdog counts down from reload to zero
// - prescale 256, full reload gives 512 s
// - watchdog counts from the 32 kHz tick
// - expiry gives reset or interrupt per bit 1
// - non-secure or matching service write reloads and restarts timeout
// - reload and control locked while in watchdog
// - normal mode uses 32 kHz tick, prescaled
// - reload is 16-bit read/write, resets zero
// - count is read-only, resets to all ones
// - control bit 8 selects count up
// - control bit 7 enables the counter
// - control bit 6 selects periodic operation
// - control bit 4 enables secure clear
// - bits 3:2 prescale 1/16/256, 11 as 00
// - bit 1 set: expiry raises interrupt, not reset
// - service write clears interrupt or restarts timeout
// - secure service must match sequence, else reset
// - zero seed always resets; sequence unreadable
`include "wdt_map.svh"

module wdt_top #(
    parameter int SRC_DIV = `WDT_SRC_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             wdt_irq,
    output logic             wdt_reset_req
);

    localparam int TW = $clog2(SRC_DIV);

    // ==========================================================
    // functions
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic wdt_pkg::wdt_pre_type pre_sel(input logic [1:0] code);
        case (code)
            2'b01:   pre_sel = wdt_pkg::WDT_PRE_DIV16;
            2'b10:   pre_sel = wdt_pkg::WDT_PRE_DIV256;
            default: pre_sel = wdt_pkg::WDT_PRE_DIV1;
        endcase
    endfunction

    // galois form of x8+x6+x5+x+1
    function automatic logic [7:0] secure_clear_sequence_generator_next(input logic [7:0] s);
        secure_clear_sequence_generator_next = {s[6:0], 1'b0} ^ (s[7] ? `WDT_SECURE_CLEAR_SEQUENCE_GENERATOR_TAPS : 8'h00);
    endfunction

    // ==========================================================
    // state
    logic [TW-1:0] tick_ff;
    logic [7:0]    pre_ff;
    logic [15:0]   reload_ff;
    logic [15:0]   count_ff;
    logic [15:0]   nxt_count;
    logic [15:0]   ctrl_ff;
    logic [7:0]    secure_clear_sequence_generator_ff;
    logic          irq_ff;
    logic          rst_ff;
    logic          aw_full_ff;
    logic          w_full_ff;
    logic [31:0]   awaddr_ff;
    logic [31:0]   wdata_ff;
    logic [3:0]    wstrb_ff;
    logic          bvalid_ff;
    logic [1:0]    bresp_ff;
    logic          rvalid_ff;
    logic [1:0]    rresp_ff;
    logic [31:0]   rdata_ff;

    // ==========================================================
    // decode
    wire wdog      = ctrl_ff[`WDT_BIT_WDOG];
    wire secure    = ctrl_ff[`WDT_BIT_SECURE];
    wire irqopt    = ctrl_ff[`WDT_BIT_IRQOPT];
    wire count_up  = ctrl_ff[`WDT_BIT_UP];
    wire cnt_en    = ctrl_ff[`WDT_BIT_EN];
    wire periodic  = ctrl_ff[`WDT_BIT_PERIODIC];
    wire tick      = (tick_ff == TW'(SRC_DIV - 1));
    wire wdt_pkg::wdt_pre_type pre = pre_sel(ctrl_ff[`WDT_BIT_PRE_HI:`WDT_BIT_PRE_LO]);
    wire pre_hit   = (pre == wdt_pkg::WDT_PRE_DIV1)
                   | ((pre == wdt_pkg::WDT_PRE_DIV16) & (pre_ff[3:0] == 4'hf))
                   | ((pre == wdt_pkg::WDT_PRE_DIV256) & (pre_ff == 8'hff));
    wire step      = tick & pre_hit;

    wire wr_fire   = aw_full_ff & w_full_ff;
    wire wr_reload = wr_fire & (awaddr_ff == `WDT_RELOAD_ADDR);
    wire wr_count  = wr_fire & (awaddr_ff == `WDT_COUNT_ADDR);
    wire wr_ctrl   = wr_fire & (awaddr_ff == `WDT_CTRL_ADDR);
    wire svc_wr    = wr_fire & (awaddr_ff == `WDT_SERVICE_ADDR);
    wire wr_hit    = wr_reload | wr_count | wr_ctrl | svc_wr;
    wire [15:0] ctrl_new = merge16(ctrl_ff, wdata_ff, wstrb_ff) & `WDT_CTRL_MASK;
    wire enter_wd  = wr_ctrl & ~wdog & ctrl_new[`WDT_BIT_WDOG];

    // a zero sequence state can never match a legal service
    wire sec_bad   = wdog & secure
                   & ((wdata_ff[7:0] != secure_clear_sequence_generator_ff) | (secure_clear_sequence_generator_ff == 8'h00));
    wire svc_ok    = svc_wr & ~sec_bad;
    wire expire    = wdog & step & (count_ff <= 16'h0001) & ~svc_ok;
    wire at_term   = count_up ? (count_ff == 16'hffff) : (count_ff == 16'h0000);
    wire nrm_term  = ~wdog & cnt_en & step & at_term;

    wire rd_reload = (araddr == `WDT_RELOAD_ADDR);
    wire rd_count  = (araddr == `WDT_COUNT_ADDR);
    wire rd_ctrl   = (araddr == `WDT_CTRL_ADDR);
    wire rd_svc    = (araddr == `WDT_SERVICE_ADDR);
    // service reads zero, keeping the sequence state hidden
    wire [31:0] rd_mux = rd_reload ? {16'h0000, reload_ff}
                       : rd_count  ? {16'h0000, count_ff}
                       : rd_ctrl   ? {16'h0000, ctrl_ff}
                       : 32'h0000_0000;

    // ==========================================================
    // bus handshakes
    assign awready       = ~aw_full_ff & ~bvalid_ff;
    assign wready        = ~w_full_ff & ~bvalid_ff;
    assign arready       = ~rvalid_ff;
    assign bvalid        = bvalid_ff;
    assign bresp         = bresp_ff;
    assign rvalid        = rvalid_ff;
    assign rresp         = rresp_ff;
    assign rdata         = rdata_ff;
    assign wdt_irq       = irq_ff;
    assign wdt_reset_req = rst_ff;

    // ==========================================================
    // write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            awaddr_ff  <= 32'h0000_0000;
        end else if (awvalid && awready) begin
            aw_full_ff <= 1'b1;
            awaddr_ff  <= awaddr;
        end else if (wr_fire) begin
            aw_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_ff <= 1'b0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else if (wvalid && wready) begin
            w_full_ff <= 1'b1;
            wdata_ff  <= wdata;
            wstrb_ff  <= wstrb;
        end else if (wr_fire) begin
            w_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= wdt_pkg::WDT_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? wdt_pkg::WDT_RESP_OKAY : wdt_pkg::WDT_RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ==========================================================
    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= wdt_pkg::WDT_RESP_OKAY;
            rdata_ff  <= 32'h0000_0000;
        end else if (arvalid && arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= (rd_reload | rd_count | rd_ctrl | rd_svc)
                         ? wdt_pkg::WDT_RESP_OKAY : wdt_pkg::WDT_RESP_SLVERR;
            rdata_ff  <= rd_mux;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ==========================================================
    // tick and prescaler; both free-run so the first step can come early by up to one period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_ff <= '0;
            pre_ff  <= 8'h00;
        end else begin
            tick_ff <= tick ? '0 : tick_ff + TW'(1);
            pre_ff  <= tick ? pre_ff + 8'h01 : pre_ff;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_ff <= `WDT_RELOAD_RST;
            ctrl_ff   <= `WDT_CTRL_RST;
        end else if (!wdog) begin
            if (wr_reload)
                reload_ff <= merge16(reload_ff, wdata_ff, wstrb_ff);
            if (wr_ctrl)
                ctrl_ff <= ctrl_new;
        end
    end

    // ==========================================================
    // counter
    always_comb begin
        nxt_count = count_ff;
        if (enter_wd) begin
            nxt_count = reload_ff;
        end else if (wdog) begin
            if (svc_ok || expire)
                nxt_count = reload_ff;
            else if (step)
                nxt_count = count_ff - 16'h0001;
        end else if (cnt_en && step) begin
            if (at_term)
                nxt_count = periodic ? reload_ff
                          : (count_up ? 16'h0000 : 16'hffff);
            else
                nxt_count = count_up ? count_ff + 16'h0001 : count_ff - 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            count_ff <= `WDT_COUNT_RST;
        else
            count_ff <= nxt_count;
    end

    // ==========================================================
    // secure sequence, interrupt and reset request
    always_ff @(posedge aclk) begin
        if (!aresetn)
            secure_clear_sequence_generator_ff <= `WDT_SECURE_CLEAR_SEQUENCE_GENERATOR_RST;
        else if (svc_wr && !wdog)
            secure_clear_sequence_generator_ff <= wdata_ff[7:0];
        else if (svc_ok && secure)
            secure_clear_sequence_generator_ff <= secure_clear_sequence_generator_next(secure_clear_sequence_generator_ff);
    end

    // a new event wins over a service clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ff <= 1'b0;
            rst_ff <= 1'b0;
        end else begin
            irq_ff <= (irq_ff & ~svc_wr) | nrm_term | (expire & irqopt);
            rst_ff <= rst_ff | (expire & ~irqopt) | (svc_wr & sec_bad);
        end
    end

    // ==========================================================
    // assertions
    property p_lock;
        @(posedge aclk) disable iff (!aresetn)
        wdog |=> $stable(ctrl_ff) && $stable(reload_ff);
    endproperty
    a_lock: assert property (p_lock) else $error("locked register changed");

    property p_enter;
        @(posedge aclk) disable iff (!aresetn)
        enter_wd |=> wdog && count_ff == $past(reload_ff);
    endproperty
    a_enter: assert property (p_enter) else $error("entry did not load");

    property p_down;
        @(posedge aclk) disable iff (!aresetn)
        wdog && step && count_ff > 16'h0001 && !svc_wr |=> count_ff == $past(count_ff) - 16'h0001;
    endproperty
    a_down: assert property (p_down) else $error("watchdog did not decrement");

    property p_expire_rst;
        @(posedge aclk) disable iff (!aresetn)
        wdog && step && count_ff <= 16'h0001 && !svc_wr && !irqopt |=> rst_ff [*3];
    endproperty
    a_expire_rst: assert property (p_expire_rst) else $error("no reset on expiry");

    property p_expire_irq;
        @(posedge aclk) disable iff (!aresetn)
        wdog && step && count_ff <= 16'h0001 && !svc_wr && irqopt && !rst_ff |=> irq_ff && !rst_ff;
    endproperty
    a_expire_irq: assert property (p_expire_irq) else $error("no irq on expiry");

    property p_service;
        @(posedge aclk) disable iff (!aresetn)
        wdog && svc_wr && !secure |=> count_ff == $past(reload_ff) && !rst_ff == !$past(rst_ff);
    endproperty
    a_service: assert property (p_service) else $error("service did not reload");

    property p_secure_bad;
        @(posedge aclk) disable iff (!aresetn)
        wdog && secure && svc_wr && (wdata_ff[7:0] != secure_clear_sequence_generator_ff || secure_clear_sequence_generator_ff == 8'h00) |=> rst_ff;
    endproperty
    a_secure_bad: assert property (p_secure_bad) else $error("bad secure service kept");

    property p_irq_hold;
        @(posedge aclk) disable iff (!aresetn)
        irq_ff && !svc_wr |=> irq_ff;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without service");

    property p_pre11;
        @(posedge aclk) disable iff (!aresetn)
        ctrl_ff[`WDT_BIT_PRE_HI:`WDT_BIT_PRE_LO] == 2'b11 |-> step == tick;
    endproperty
    a_pre11: assert property (p_pre11) else $error("prescale 11 not divide by 1");

    property p_halt;
        @(posedge aclk) disable iff (!aresetn)
        !wdog && !cnt_en && !wr_ctrl |=> $stable(count_ff);
    endproperty
    a_halt: assert property (p_halt) else $error("halted counter moved");

    property p_up;
        @(posedge aclk) disable iff (!aresetn)
        !wdog && cnt_en && count_up && step && count_ff != 16'hffff && !wr_ctrl
        |=> count_ff == $past(count_ff) + 16'h0001;
    endproperty
    a_up: assert property (p_up) else $error("up count wrong");

endmodule

// ==== shared/wdt_map.svh ====
// register map, field positions, reset values and timing counts of the watchdog timer unit
// assumes a 32-bit AXI4-Lite byte address and a 250 MHz aclk
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ==========================================================
// register byte addresses
`define WDT_RELOAD_ADDR    32'hffff0360
`define WDT_COUNT_ADDR     32'hffff0364
`define WDT_CTRL_ADDR      32'hffff0368
`define WDT_SERVICE_ADDR   32'hffff036c

// ==========================================================
// reset values and masks
`define WDT_RELOAD_RST     16'h0000
`define WDT_COUNT_RST      16'hffff
`define WDT_CTRL_RST       16'h0000
`define WDT_SECURE_CLEAR_SEQUENCE_GENERATOR_RST       8'h00
`define WDT_CTRL_MASK      16'h01fe
`define WDT_SECURE_CLEAR_SEQUENCE_GENERATOR_TAPS      8'h63

// ==========================================================
// control field positions
`define WDT_BIT_UP         8
`define WDT_BIT_EN         7
`define WDT_BIT_PERIODIC   6
`define WDT_BIT_WDOG       5
`define WDT_BIT_SECURE     4
`define WDT_BIT_PRE_HI     3
`define WDT_BIT_PRE_LO     2
`define WDT_BIT_IRQOPT     1

// ==========================================================
// timing: 32.768 kHz source period, derived from the aclk period
`define WDT_SRC_PERIOD_PS  30517578
`define WDT_CLK_PERIOD_PS  4000
`define WDT_SRC_CYCLES     (`WDT_SRC_PERIOD_PS / `WDT_CLK_PERIOD_PS)
`define WDT_MAX_TIMEOUT_S  512

`endif

// ==== shared/wdt_pkg.sv ====
// types shared by the watchdog timer unit
// assumes nothing beyond a SystemVerilog compiler
package wdt_pkg;

    typedef enum logic [1:0] {
        WDT_RESP_OKAY   = 2'b00,
        WDT_RESP_SLVERR = 2'b10
    } wdt_resp_type;

    typedef enum logic [2:0] {
        WDT_PRE_DIV1   = 3'b001,
        WDT_PRE_DIV16  = 3'b010,
        WDT_PRE_DIV256 = 3'b100
    } wdt_pre_type;

endpackage
